// >>> rtl/tile_status_regs.sv
// Processor status register bank: ring oscillators, RAM size, debug state.
// Assumes status instructions give one-cycle read/write strobes on mclk.
//
// Functional notes
// - Four free-running oscillators clock counters; count in bits 15:0, rest zero.
// - Control bit 1 enables core oscillators, bit 0 peripheral; both reset zero.
// - Oscillators run asynchronously to the tile clock, usable as randomness.
// - Counters at 0x07 tile cell, 0x08 tile wire, 0x09, 0x0A peripheral.
// - Oscillator counts survive system reset.
// - RAM size in bytes in bits 31:2; bits 1:0 read zero.
// - Debug entry captures status: asid 10, entry issue 9, issue 8, fast 7, paused 6.
// - Status bit 4 kernel, 3 interrupt, 2 event sequence, 1 irq en, 0 event en.
// - Debug entry captures 32-bit saved program counter.
// - Debug entry captures 32-bit saved stack pointer.
// - Second operand holds register number in bits 4:0, upper bits zero.
// - Cause code in bits 2:0, reset zero, codes one to five.
// - Bits 17:16 hold lowest firing breakpoint; zero for host and debug call.
// - Bits 15:8 hold causing thread; zero for host requests.
// - Data watchpoint stores address; resource watchpoint stores resource id.
// - Per-thread stop mask 7:0 holds threads stopped outside debug mode.
// - Marked cores stay stopped after return from debug interrupt.
module tile_status_regs
  import tile_status_pkg::*;
#(
  parameter logic [DATA_W-1:0] RAM_BYTES = 32'h0008_0000
)
(
  input wire logic mclk,
  input wire logic rstn,
  // Status instruction port
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wr_data,
  output logic [DATA_W-1:0] rd_data,
  output logic rd_valid,
  // Ring oscillator sources
  input wire logic tile_cell_ring,
  input wire logic tile_wire_ring,
  input wire logic periph_cell_ring,
  input wire logic periph_wire_ring,
  // Core state
  input wire logic debug_mode,
  input wire logic debug_entry,
  input wire logic [DATA_W-1:0] saved_status_word,
  input wire logic [DATA_W-1:0] saved_program_counter,
  input wire logic [DATA_W-1:0] saved_stack_pointer,
  input wire logic [2:0] entry_cause,
  input wire logic [CAUSE_THREAD_W-1:0] entry_thread,
  input wire logic [NUM_BP-1:0] entry_bp_hits,
  input wire logic [DATA_W-1:0] entry_data,
  output logic [NUM_THREADS-1:0] thread_stop,
  output logic [DATA_W-1:0] debug_read_core_id,
  output logic [4:0] debug_read_reg_num
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [CAUSE_BP_W-1:0] lowest_hit(input logic [NUM_BP-1:0] hits);
    logic [CAUSE_BP_W-1:0] idx;
    idx = '0;
    for (int i = NUM_BP - 1; i >= 0; i--)
    begin
      if (hits[i])
      begin
        idx = CAUSE_BP_W'(i);
      end
    end
    return idx;
  endfunction

  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_v,
                                              input logic [DATA_W-1:0] new_v,
                                              input logic [DATA_W-1:0] mask);
    return (old_v & ~mask) | (new_v & mask);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Write decode

  logic osc_ctl_we;
  logic dbg_we;
  assign osc_ctl_we = wr_en && (addr == OFS_RING_OSC_CONTROL);
  assign dbg_we = wr_en && debug_mode;

  wire status_we = dbg_we && (addr == OFS_DBG_STATUS);
  wire pc_we = dbg_we && (addr == OFS_DBG_PC);
  wire sp_we = dbg_we && (addr == OFS_DBG_SP);
  wire core_id_we = dbg_we && (addr == OFS_DBG_CORE_ID);
  wire reg_num_we = dbg_we && (addr == OFS_DBG_REG_NUM);
  wire cause_we = dbg_we && (addr == OFS_DBG_CAUSE);
  wire info_we = dbg_we && (addr == OFS_DBG_INFO);
  wire stop_we = dbg_we && (addr == OFS_DBG_STOP);

  ////////////////////////////////////////////////////////////////////////////
  // Ring oscillators

  logic [1:0] osc_en_q;
  logic [1:0] osc_en_d;
  assign osc_en_d = osc_ctl_we ? wr_data[1:0] : osc_en_q;

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      osc_en_q <= 2'h0;
    end
    else
    begin
      osc_en_q <= osc_en_d;
    end
  end

  wire core_en = osc_en_q[OSC_CORE_EN_BIT];
  wire periph_en = osc_en_q[OSC_PERIPH_EN_BIT];

  logic [3:0] ring_in;
  logic [3:0] ring_en;
  logic [3:0] osc_clk;
  logic [OSC_W-1:0] osc_count [4];
  assign ring_in = {periph_wire_ring, periph_cell_ring, tile_wire_ring, tile_cell_ring};
  assign ring_en = {periph_en, periph_en, core_en, core_en};

  // Sample only while all stopped: counter settles before capture
  wire osc_sample = !core_en && !periph_en;

  for (genvar g = 0; g < 4; g++)
  begin : g_osc
    ring_osc u_ring (
      .ring_in(ring_in[g]),
      .enable(ring_en[g]),
      .osc_clk(osc_clk[g])
    );
    osc_counter #(.W(OSC_W)) u_cnt (
      .osc_clk(osc_clk[g]),
      .mclk(mclk),
      .sample(osc_sample),
      .count_q(osc_count[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Debug state

  logic [DATA_W-1:0] status_q;
  logic [DATA_W-1:0] pc_q;
  logic [DATA_W-1:0] sp_q;
  logic [DATA_W-1:0] core_id_q;
  logic [DATA_W-1:0] reg_num_q;
  logic [DATA_W-1:0] cause_q;
  logic [DATA_W-1:0] info_q;
  logic [DATA_W-1:0] stop_q;

  logic [DATA_W-1:0] entry_cause_word;
  logic entry_hw_bp;
  logic entry_is_host;
  logic [CAUSE_BP_W-1:0] entry_bp_idx;
  assign entry_hw_bp = (entry_cause == CAUSE_IBREAK) || (entry_cause == CAUSE_DWATCH)
                       || (entry_cause == CAUSE_RWATCH);
  assign entry_is_host = (entry_cause == CAUSE_HOST);
  assign entry_bp_idx = entry_hw_bp ? lowest_hit(entry_bp_hits) : '0;
  assign entry_cause_word = {14'h0000, entry_bp_idx,
                             entry_is_host ? 8'h00 : entry_thread,
                             5'h00, entry_cause};

  wire [DATA_W-1:0] status_d = debug_entry ? (saved_status_word & STATUS_RD_MASK)
                             : status_we ? merge(status_q, wr_data, STATUS_WR_MASK) : status_q;
  wire [DATA_W-1:0] pc_d = debug_entry ? saved_program_counter : pc_we ? wr_data : pc_q;
  wire [DATA_W-1:0] sp_d = debug_entry ? saved_stack_pointer : sp_we ? wr_data : sp_q;
  // Writable cause fields: breakpoint index, thread and code
  localparam logic [DATA_W-1:0] CAUSE_WR_MASK = {14'h0000, {CAUSE_BP_W{1'b1}}, {CAUSE_THREAD_W{1'b1}}, 5'h00,
                                                {CAUSE_CODE_W{1'b1}}};
  wire [DATA_W-1:0] cause_d = debug_entry ? entry_cause_word
                            : cause_we ? (wr_data & CAUSE_WR_MASK) : cause_q;
  // Data or resource watchpoint carries its word; other causes keep old data
  wire entry_has_data = (entry_cause == CAUSE_DWATCH) || (entry_cause == CAUSE_RWATCH);
  wire [DATA_W-1:0] info_d = (debug_entry && entry_has_data) ? entry_data
                           : info_we ? wr_data : info_q;

  // Entry capture wins over a concurrent debugger write
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      status_q <= ZERO_WORD;
      pc_q <= ZERO_WORD;
      sp_q <= ZERO_WORD;
      core_id_q <= ZERO_WORD;
      reg_num_q <= ZERO_WORD;
      cause_q <= ZERO_WORD;
      info_q <= ZERO_WORD;
      stop_q <= ZERO_WORD;
    end
    else
    begin
      status_q <= status_d;
      pc_q <= pc_d;
      sp_q <= sp_d;
      core_id_q <= core_id_we ? wr_data : core_id_q;
      reg_num_q <= reg_num_we ? (wr_data & REG_NUM_MASK) : reg_num_q;
      cause_q <= cause_d;
      info_q <= info_d;
      stop_q <= stop_we ? (wr_data & STOP_MASK) : stop_q;
    end
  end

  // Mask applies only outside debug mode, so resume leaves them halted
  assign thread_stop = debug_mode ? '0 : stop_q[NUM_THREADS-1:0];
  assign debug_read_core_id = core_id_q;
  assign debug_read_reg_num = reg_num_q[4:0];

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  logic [DATA_W-1:0] rd_mux;
  always_comb
  begin
    case (addr)
      OFS_RING_OSC_CONTROL: rd_mux = {30'h0000_0000, osc_en_q};
      OFS_TILE_CELL_OSC: rd_mux = {OSC_ZERO, osc_count[0]};
      OFS_TILE_WIRE_OSC: rd_mux = {OSC_ZERO, osc_count[1]};
      OFS_PERIPH_CELL_OSC: rd_mux = {OSC_ZERO, osc_count[2]};
      OFS_PERIPH_WIRE_OSC: rd_mux = {OSC_ZERO, osc_count[3]};
      OFS_RAM_SIZE: rd_mux = RAM_BYTES & RAM_SIZE_MASK;
      OFS_DBG_STATUS: rd_mux = status_q;
      OFS_DBG_PC: rd_mux = pc_q;
      OFS_DBG_SP: rd_mux = sp_q;
      OFS_DBG_CORE_ID: rd_mux = core_id_q;
      OFS_DBG_REG_NUM: rd_mux = reg_num_q;
      OFS_DBG_CAUSE: rd_mux = cause_q;
      OFS_DBG_INFO: rd_mux = info_q;
      OFS_DBG_STOP: rd_mux = stop_q;
      default: rd_mux = ZERO_WORD;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      rd_data <= ZERO_WORD;
      rd_valid <= 1'b0;
    end
    else
    begin
      rd_valid <= rd_en;
      if (rd_en)
      begin
        rd_data <= rd_mux;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_osc_ctl_write;
    @(posedge mclk) disable iff (!rstn)
      osc_ctl_we |=> osc_en_q == $past(wr_data[1:0]);
  endproperty
  a_osc_ctl_write: assert property (p_osc_ctl_write) else $error("osc control write lost");

  property p_no_write_outside_debug;
    @(posedge mclk) disable iff (!rstn)
      (wr_en && !debug_mode && !debug_entry) |=> $stable(status_q) && $stable(pc_q) && $stable(stop_q);
  endproperty
  a_no_write_outside_debug: assert property (p_no_write_outside_debug) else $error("debug reg written");

  property p_pc_capture;
    @(posedge mclk) disable iff (!rstn)
      debug_entry |=> pc_q == $past(saved_program_counter);
  endproperty
  a_pc_capture: assert property (p_pc_capture) else $error("pc not captured");

  property p_sp_capture;
    @(posedge mclk) disable iff (!rstn)
      debug_entry |=> sp_q == $past(saved_stack_pointer);
  endproperty
  a_sp_capture: assert property (p_sp_capture) else $error("sp not captured");

  property p_status_bit8_ro;
    @(posedge mclk) disable iff (!rstn)
      !debug_entry |=> status_q[8] == $past(status_q[8]);
  endproperty
  a_status_bit8_ro: assert property (p_status_bit8_ro) else $error("status bit 8 written");

  property p_host_zero_fields;
    @(posedge mclk) disable iff (!rstn)
      (debug_entry && entry_cause == CAUSE_HOST) |=> cause_q[17:8] == 10'h000 && cause_q[2:0] == 3'h1;
  endproperty
  a_host_zero_fields: assert property (p_host_zero_fields) else $error("host cause fields");

  property p_stop_outside_debug;
    @(posedge mclk) disable iff (!rstn)
      !debug_mode |-> thread_stop == stop_q[7:0] && ($past(debug_mode) || $stable(thread_stop));
  endproperty
  a_stop_outside_debug: assert property (p_stop_outside_debug) else $error("stop mask not applied");

  property p_reg_num_upper;
    @(posedge mclk) disable iff (!rstn)
      reg_num_we |=> reg_num_q[31:5] == 27'h0 ##1 reg_num_q[31:5] == 27'h0;
  endproperty
  a_reg_num_upper: assert property (p_reg_num_upper) else $error("reg num upper bits");

  property p_read_latency;
    @(posedge mclk) disable iff (!rstn)
      (rd_en && addr == OFS_RAM_SIZE) |=> rd_valid && rd_data[1:0] == 2'h0;
  endproperty
  a_read_latency: assert property (p_read_latency) else $error("ram size read");

  property p_count_frozen_while_running;
    @(posedge mclk) disable iff (!rstn)
      (core_en || periph_en) |=> $stable(osc_count[0]) && $stable(osc_count[1])
                                 && $stable(osc_count[2]) && $stable(osc_count[3]);
  endproperty
  a_count_frozen_while_running: assert property (p_count_frozen_while_running) else $error("count moved");

  property p_stop_write;
    @(posedge mclk) disable iff (!rstn)
      stop_we |=> stop_q[31:8] == 24'h00_0000 && stop_q[7:0] == $past(wr_data[7:0]);
  endproperty
  a_stop_write: assert property (p_stop_write) else $error("stop mask write");

  property p_debug_call_instruction_fields;
    @(posedge mclk) disable iff (!rstn)
      (debug_entry && entry_cause == CAUSE_DEBUG_CALL_INSTRUCTION) |=>
        cause_q[17:16] == 2'h0 && cause_q[15:8] == $past(entry_thread) && cause_q[2:0] == 3'h2;
  endproperty
  a_debug_call_instruction_fields: assert property (p_debug_call_instruction_fields) else $error("debug call cause fields");

  property p_bp_lowest_hit;
    @(posedge mclk) disable iff (!rstn)
      (debug_entry && entry_hw_bp && entry_bp_hits != 4'h0) |=>
        ((($past(entry_bp_hits) >> cause_q[17:16]) << cause_q[17:16]) == $past(entry_bp_hits))
        && ((($past(entry_bp_hits) >> cause_q[17:16]) & 4'h1) == 4'h1);
  endproperty
  a_bp_lowest_hit: assert property (p_bp_lowest_hit) else $error("breakpoint index not lowest hit");

  property p_info_capture;
    @(posedge mclk) disable iff (!rstn)
      (debug_entry && (entry_cause == CAUSE_DWATCH || entry_cause == CAUSE_RWATCH)) |=>
        info_q == $past(entry_data);
  endproperty
  a_info_capture: assert property (p_info_capture) else $error("watchpoint data not captured");

  // Valid only follows a taken read
  property p_rd_valid_idle;
    @(posedge mclk) disable iff (!rstn)
      !rd_en |=> !rd_valid;
  endproperty
  a_rd_valid_idle: assert property (p_rd_valid_idle) else $error("read valid without read");
endmodule

// >>> rtl/tile_status_pkg.sv
// Package for the tile status and debug register bank.
// Assumes a single core clock; oscillators are free-running elsewhere.
package tile_status_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int OSC_W = 16;
  localparam int NUM_THREADS = 8;

  localparam logic [ADDR_W-1:0] OFS_RING_OSC_CONTROL = 8'h06;
  localparam logic [ADDR_W-1:0] OFS_TILE_CELL_OSC = 8'h07;
  localparam logic [ADDR_W-1:0] OFS_TILE_WIRE_OSC = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_PERIPH_CELL_OSC = 8'h09;
  localparam logic [ADDR_W-1:0] OFS_PERIPH_WIRE_OSC = 8'h0A;
  localparam logic [ADDR_W-1:0] OFS_RAM_SIZE = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_DBG_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_DBG_PC = 8'h11;
  localparam logic [ADDR_W-1:0] OFS_DBG_SP = 8'h12;
  localparam logic [ADDR_W-1:0] OFS_DBG_CORE_ID = 8'h13;
  localparam logic [ADDR_W-1:0] OFS_DBG_REG_NUM = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_DBG_CAUSE = 8'h15;
  localparam logic [ADDR_W-1:0] OFS_DBG_INFO = 8'h16;
  localparam logic [ADDR_W-1:0] OFS_DBG_STOP = 8'h18;

  // Oscillator control fields
  localparam int OSC_CORE_EN_BIT = 1;
  localparam int OSC_PERIPH_EN_BIT = 0;

  // Saved status writable bits: 10,9,7,6,4..0; bit 8 is read-only
  localparam logic [DATA_W-1:0] STATUS_WR_MASK = 32'h0000_06DF;
  localparam logic [DATA_W-1:0] STATUS_RD_MASK = 32'h0000_07DF;
  localparam logic [DATA_W-1:0] REG_NUM_MASK = 32'h0000_001F;
  localparam logic [DATA_W-1:0] STOP_MASK = 32'h0000_00FF;
  localparam logic [DATA_W-1:0] RAM_SIZE_MASK = 32'hFFFF_FFFC;

  // Cause register fields
  localparam int CAUSE_CODE_LSB = 0;
  localparam int CAUSE_CODE_W = 3;
  localparam int CAUSE_THREAD_LSB = 8;
  localparam int CAUSE_THREAD_W = 8;
  localparam int CAUSE_BP_LSB = 16;
  localparam int CAUSE_BP_W = 2;
  localparam int NUM_BP = 4;

  typedef enum logic [2:0] {
    CAUSE_NONE = 3'h0,
    CAUSE_HOST = 3'h1,
    CAUSE_DEBUG_CALL_INSTRUCTION = 3'h2,
    CAUSE_IBREAK = 3'h3,
    CAUSE_DWATCH = 3'h4,
    CAUSE_RWATCH = 3'h5
  } irq_cause_t;

  localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [OSC_W-1:0] OSC_ZERO = 16'h0000;
endpackage

// >>> rtl/osc_counter.sv
// Free-running oscillator counter, sampled into the core clock domain.
// Assumes osc_clk is a ring oscillator output, asynchronous to mclk.
module osc_counter
  import tile_status_pkg::*;
#(
  parameter int W = OSC_W
)
(
  input wire logic osc_clk,
  input wire logic mclk,
  input wire logic sample,
  output logic [W-1:0] count_q
);
  // Power-up value only; no system reset, so the count survives it
  logic [W-1:0] osc_cnt_q = '0;

  always_ff @(posedge osc_clk)
  begin
    osc_cnt_q <= osc_cnt_q + W'(1);
  end

  // Plain capture; software stops the oscillator first so the count is stable
  always_ff @(posedge mclk)
  begin
    if (sample)
    begin
      count_q <= osc_cnt_q;
    end
  end
endmodule

// >>> rtl/ring_osc.sv
// Behavioural ring-oscillator stand-in with enable gate.
// Assumes ring_in is the raw oscillator from the analog macro.
module ring_osc (
  input wire logic ring_in,
  input wire logic enable,
  output logic osc_clk
);
  // Glitch-free gating belongs to the macro; here a plain AND
  assign osc_clk = ring_in & enable;
endmodule

// >>> verif/ring_osc_source.sv
// Far-side stand-in: four raw ring oscillators that never stop.
// Assumes the bank gates and counts them; periods are unrelated to mclk.
module ring_osc_source (
  output logic tile_cell_ring,
  output logic tile_wire_ring,
  output logic periph_cell_ring,
  output logic periph_wire_ring
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    tile_cell_ring = 1'b0;
    tile_wire_ring = 1'b0;
    periph_cell_ring = 1'b1;
    periph_wire_ring = 1'b1;
  end

  // Odd periods keep the rings drifting against mclk
  always #1.37 tile_cell_ring = ~tile_cell_ring;
  always #1.91 tile_wire_ring = ~tile_wire_ring;
  always #2.23 periph_cell_ring = ~periph_cell_ring;
  always #2.71 periph_wire_ring = ~periph_wire_ring;
endmodule

// >>> verif/tile_status_regs_tb.sv
// Self-checking bench for the status register bank.
// Assumes the ring source model drives the four raw oscillator inputs.
module tile_status_regs_tb;
  import tile_status_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [DATA_W-1:0] RAM_CFG = 32'h0006_1003;
  localparam int TIMEOUT_CYCLES = 20000;
  logic mclk, rstn, wr_en, rd_en, rd_valid, debug_mode, debug_entry;
  logic tcr, twr, pcr, pwr;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wr_data, rd_data, saved_status_word, saved_program_counter, saved_stack_pointer;
  logic [DATA_W-1:0] entry_data, debug_read_core_id, got, d, info_exp;
  logic [DATA_W-1:0] osc_a [4];
  logic [DATA_W-1:0] osc_b [4];
  logic [2:0] entry_cause;
  logic [7:0] entry_thread, thread_stop;
  logic [3:0] entry_bp_hits;
  logic [4:0] debug_read_reg_num;
  int mismatches = 0;
  int n_checks = 0;
  int cycles = 0;

  ring_osc_source ring_osc_source_i (.tile_cell_ring(tcr), .tile_wire_ring(twr),
    .periph_cell_ring(pcr), .periph_wire_ring(pwr));
  tile_status_regs #(.RAM_BYTES(RAM_CFG)) tile_status_regs_i (.mclk(mclk), .rstn(rstn),
    .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wr_data(wr_data), .rd_data(rd_data),
    .rd_valid(rd_valid), .tile_cell_ring(tcr), .tile_wire_ring(twr), .periph_cell_ring(pcr),
    .periph_wire_ring(pwr), .debug_mode(debug_mode), .debug_entry(debug_entry),
    .saved_status_word(saved_status_word), .saved_program_counter(saved_program_counter),
    .saved_stack_pointer(saved_stack_pointer), .entry_cause(entry_cause),
    .entry_thread(entry_thread), .entry_bp_hits(entry_bp_hits), .entry_data(entry_data),
    .thread_stop(thread_stop), .debug_read_core_id(debug_read_core_id),
    .debug_read_reg_num(debug_read_reg_num));

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == TIMEOUT_CYCLES)
    begin
      mismatches++;
      $display("MISMATCH timeout expected done seen hang");
      print_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] seen);
    n_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge mclk);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= v;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask

  // Answer is fixed at the same edge that takes the strobe
  task automatic reg_rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    @(posedge mclk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1;
    chk("rd_valid", 32'h0000_0001, {31'h0, rd_valid});
    v = rd_data;
  endtask

  task automatic reg_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp, input string what);
    logic [DATA_W-1:0] v;
    reg_rd(a, v);
    chk(what, exp, v);
  endtask

  task automatic read_osc();
    for (int j = 0; j < 4; j++)
    begin
      osc_a[j] = osc_b[j];
      reg_rd(OFS_TILE_CELL_OSC + ADDR_W'(j), osc_b[j]);
      chk("osc_upper", ZERO_WORD, {osc_b[j][31:16], 16'h0000});
    end
  endtask

  task automatic enter(input logic [2:0] c);
    @(posedge mclk);
    debug_mode <= 1'b1;
    debug_entry <= 1'b1;
    entry_cause <= c;
    saved_status_word <= $urandom();
    saved_program_counter <= $urandom();
    saved_stack_pointer <= $urandom();
    entry_thread <= 8'($urandom());
    entry_bp_hits <= 4'($urandom_range(15, 1));
    entry_data <= $urandom();
    @(posedge mclk);
    debug_entry <= 1'b0;
  endtask

  function automatic logic [DATA_W-1:0] cause_word(logic [2:0] c, logic [7:0] t, logic [3:0] h);
    logic [1:0] bp;
    bp = 2'h0;
    for (int i = 3; i >= 0; i--)
      if (h[i])
        bp = 2'(i);
    if (c < 3'h3)
      bp = 2'h0;
    if (c == 3'h1)
      t = 8'h00;
    return {14'h0, bp, t, 5'h00, c};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rstn = 1'b0;
    {wr_en, rd_en, debug_mode, debug_entry} = 4'h0;
    addr = 8'h00;
    {wr_data, saved_status_word, saved_program_counter, saved_stack_pointer, entry_data} = '0;
    entry_cause = 3'h0;
    entry_thread = 8'h00;
    entry_bp_hits = 4'h0;
    info_exp = ZERO_WORD;
    void'($urandom(67));
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    reg_chk(OFS_RING_OSC_CONTROL, ZERO_WORD, "osc_control_reset");
    reg_chk(OFS_DBG_CAUSE, ZERO_WORD, "cause_reset");
    reg_chk(OFS_RAM_SIZE, {RAM_CFG[31:2], 2'b00}, "ram_size");
    reg_wr(OFS_RAM_SIZE, 32'hFFFF_FFFF);
    reg_chk(OFS_RAM_SIZE, {RAM_CFG[31:2], 2'b00}, "ram_size_ro");
    reg_chk(8'h0B, ZERO_WORD, "unmapped");
    reg_wr(OFS_RING_OSC_CONTROL, 32'hFFFF_FFFF);
    reg_chk(OFS_RING_OSC_CONTROL, 32'h0000_0003, "osc_control");
    reg_wr(OFS_RING_OSC_CONTROL, ZERO_WORD);
    repeat (12) @(posedge mclk);
    read_osc();
    // Peripheral pair first, then core pair: only the enabled pair may move
    for (int k = 0; k < 2; k++)
    begin
      reg_wr(OFS_RING_OSC_CONTROL, k ? 32'h0000_0002 : 32'h0000_0001);
      repeat (50) @(posedge mclk);
      reg_wr(OFS_RING_OSC_CONTROL, ZERO_WORD);
      repeat (12) @(posedge mclk);
      read_osc();
      for (int j = 0; j < 4; j++)
        chk("osc_moved", {31'h0, (j < 2) == (k == 1)}, {31'h0, osc_a[j] !== osc_b[j]});
    end
    rstn <= 1'b0;
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    read_osc();
    for (int j = 0; j < 4; j++)
      chk("osc_kept", osc_a[j], osc_b[j]);
    for (int c = 1; c <= 5; c++)
    begin
      enter(3'(c));
      if (c >= 4)
        info_exp = entry_data;
      reg_chk(OFS_DBG_STATUS, saved_status_word & STATUS_RD_MASK, "status");
      reg_chk(OFS_DBG_PC, saved_program_counter, "pc");
      reg_chk(OFS_DBG_SP, saved_stack_pointer, "sp");
      reg_chk(OFS_DBG_CAUSE, cause_word(3'(c), entry_thread, entry_bp_hits), "cause");
      reg_chk(OFS_DBG_INFO, info_exp, "info");
    end
    d = $urandom();
    reg_wr(OFS_DBG_CORE_ID, d);
    reg_chk(OFS_DBG_CORE_ID, d, "core_id");
    chk("core_id_out", d, debug_read_core_id);
    d = $urandom();
    reg_wr(OFS_DBG_REG_NUM, d);
    reg_chk(OFS_DBG_REG_NUM, {27'h0, d[4:0]}, "reg_num");
    chk("reg_num_out", {27'h0, d[4:0]}, {27'h0, debug_read_reg_num});
    reg_wr(OFS_DBG_STATUS, 32'hFFFF_FFFF);
    reg_chk(OFS_DBG_STATUS, (saved_status_word & 32'h0000_0100) | 32'h0000_06DF, "status_wr");
    d = $urandom();
    reg_wr(OFS_DBG_CAUSE, d);
    reg_chk(OFS_DBG_CAUSE, d & 32'h0003_FF07, "cause_wr");
    d = $urandom();
    reg_wr(OFS_DBG_STOP, d);
    reg_chk(OFS_DBG_STOP, {24'h0, d[7:0]}, "stop_mask");
    chk("stop_in_debug", ZERO_WORD, {24'h0, thread_stop});
    @(posedge mclk);
    debug_mode <= 1'b0;
    @(posedge mclk);
    #1;
    chk("stop_after_return", {24'h0, d[7:0]}, {24'h0, thread_stop});
    reg_wr(OFS_DBG_STOP, ~d);
    reg_chk(OFS_DBG_STOP, {24'h0, d[7:0]}, "stop_locked");
    reg_wr(OFS_DBG_PC, ~saved_program_counter);
    reg_chk(OFS_DBG_PC, saved_program_counter, "pc_locked");
    print_verdict();
  end
endmodule
